/* File: hdl/iod_io_space_map.vh */
// constants for the i/o space decoder: request kinds, address windows, bit masks
`ifndef IOD_IO_SPACE_MAP_VH
`define IOD_IO_SPACE_MAP_VH
// request kinds
`define IOD_K_PORT_RD 3'h0
`define IOD_K_PORT_WR 3'h1
`define IOD_K_MEM_RD 3'h2
`define IOD_K_MEM_WR 3'h3
`define IOD_K_BIT_SET 3'h4
`define IOD_K_BIT_CLR 3'h5
`define IOD_K_SKIP_SET 3'h6
`define IOD_K_SKIP_CLR 3'h7
// address windows
`define IOD_IO_OFS 8'h20
`define IOD_EXT_BASE 8'h60
`define IOD_IO_WIDTH 6
`define IOD_IO_COUNT 64
`define IOD_BIT_TOP_HI 3'h0
`define IOD_ZERO8 8'h00
`define IOD_ONE8 8'h01
// locations used by the core
`define IOD_A_SP_LOW 6'h3D
`define IOD_A_SP_HIGH 6'h3E
`define IOD_A_STATUS 6'h3F
// other implemented i/o locations
`define IOD_A_PIO_B_IN 6'h03
`define IOD_A_PIO_B_DIR 6'h04
`define IOD_A_PIO_B_OUT 6'h05
`define IOD_A_PIO_C_IN 6'h06
`define IOD_A_PIO_C_DIR 6'h07
`define IOD_A_PIO_C_OUT 6'h08
`define IOD_A_PIO_D_IN 6'h09
`define IOD_A_PIO_D_DIR 6'h0A
`define IOD_A_PIO_D_OUT 6'h0B
`define IOD_A_T0_FLAGS 6'h15
`define IOD_A_T1_FLAGS 6'h16
`define IOD_A_T2_FLAGS 6'h17
`define IOD_A_PIN_CHG_FLAGS 6'h1B
`define IOD_A_EXT_INT_FLAGS 6'h1C
`define IOD_A_EXT_INT_MASK 6'h1D
`define IOD_A_GP0 6'h1E
`define IOD_A_NVM_CTRL 6'h1F
`define IOD_A_NVM_DATA 6'h20
`define IOD_A_NVM_ADDR_LO 6'h21
`define IOD_A_NVM_ADDR_HI 6'h22
`define IOD_A_TMR_GEN 6'h23
`define IOD_A_T0_CTRL_A 6'h24
`define IOD_A_T0_CTRL_B 6'h25
`define IOD_A_T0_COUNT 6'h26
`define IOD_A_T0_CMP_A 6'h27
`define IOD_A_T0_CMP_B 6'h28
`define IOD_A_GP1 6'h2A
`define IOD_A_GP2 6'h2B
`define IOD_A_SER_CTRL 6'h2C
`define IOD_A_SER_STATUS 6'h2D
`define IOD_A_SER_DATA 6'h2E
`define IOD_A_CMP_CTRL 6'h30
`define IOD_A_SLEEP_CTRL 6'h33
`define IOD_A_RST_CAUSE 6'h34
`define IOD_A_CORE_CTRL 6'h35
`define IOD_A_SELF_PROG 6'h37
// writable bit masks per i/o location
`define IOD_M_PORT_C 8'h7F
`define IOD_M_FULL 8'hFF
`define IOD_M_TFLAG 8'h07
`define IOD_M_TFLAG1 8'h27
`define IOD_M_EXTFLAG 8'h03
`define IOD_M_NVM_CTRL 8'h3F
`define IOD_M_TMR_GEN 8'h83
`define IOD_M_T0A 8'hF3
`define IOD_M_T0B 8'hCF
`define IOD_M_SER_STATUS 8'hC1
`define IOD_M_SLEEP 8'h0F
`define IOD_M_RSTCAUSE 8'h0F
`define IOD_M_CORECTL 8'h13
`define IOD_M_SELFPROG 8'hDF
`define IOD_M_SP_HIGH 8'h07
// write-one-to-clear masks
`define IOD_C_ACI 8'h10
`endif

/* File: hdl/iod_io_space_decoder.v */
// i/o register space decoder and register bank for an 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "iod_io_space_map.vh"
module iod_io_space_decoder (
   // clock and reset
   input wire ref_clk,
   input wire srst,
   // request from the core
   input wire req_valid,
   input wire [2:0] req_kind,
   input wire [7:0] req_addr,
   input wire [2:0] req_bit,
   input wire [7:0] req_wdata,
   output wire req_ready,
   // answer to the core
   output reg resp_valid_q,
   output reg [7:0] rdata_q,
   output reg skip_q,
   // hardware flag events from peripherals
   input wire evt_valid,
   input wire [5:0] evt_addr,
   input wire [7:0] evt_bits,
   // extended i/o window
   output reg ext_rd_q,
   output reg ext_wr_q,
   output reg [7:0] ext_addr_q,
   output reg [7:0] ext_wdata_q,
   input wire [7:0] ext_rdata,
   // core state held in the bank
   output wire [7:0] core_status,
   output wire [10:0] stack_ptr
);
   reg [7:0] io_q [0:`IOD_IO_COUNT-1];
   reg [7:0] io_d [0:`IOD_IO_COUNT-1];
   reg [5:0] idx;
   reg [7:0] wr_val;
   reg [7:0] wm;
   reg [7:0] cm;
   reg [7:0] old;
   reg [7:0] bm;
   reg [7:0] plain;
   reg [7:0] mem_io_addr;
   integer i;
   integer j;

   // writable bits of each location; zero marks a reserved one
   function [7:0] wmask;
      input [5:0] a;
      begin
         case (a)
            `IOD_A_PIO_B_IN: wmask = `IOD_M_FULL;
            `IOD_A_PIO_B_DIR: wmask = `IOD_M_FULL;
            `IOD_A_PIO_B_OUT: wmask = `IOD_M_FULL;
            `IOD_A_PIO_C_IN: wmask = `IOD_M_PORT_C;
            `IOD_A_PIO_C_DIR: wmask = `IOD_M_PORT_C;
            `IOD_A_PIO_C_OUT: wmask = `IOD_M_PORT_C;
            `IOD_A_PIO_D_IN: wmask = `IOD_M_FULL;
            `IOD_A_PIO_D_DIR: wmask = `IOD_M_FULL;
            `IOD_A_PIO_D_OUT: wmask = `IOD_M_FULL;
            `IOD_A_T0_FLAGS: wmask = `IOD_M_TFLAG;
            `IOD_A_T1_FLAGS: wmask = `IOD_M_TFLAG1;
            `IOD_A_T2_FLAGS: wmask = `IOD_M_TFLAG;
            `IOD_A_PIN_CHG_FLAGS: wmask = `IOD_M_TFLAG;
            `IOD_A_EXT_INT_FLAGS: wmask = `IOD_M_EXTFLAG;
            `IOD_A_EXT_INT_MASK: wmask = `IOD_M_EXTFLAG;
            `IOD_A_GP0: wmask = `IOD_M_FULL;
            `IOD_A_NVM_CTRL: wmask = `IOD_M_NVM_CTRL;
            `IOD_A_NVM_DATA: wmask = `IOD_M_FULL;
            `IOD_A_NVM_ADDR_LO: wmask = `IOD_M_FULL;
            `IOD_A_NVM_ADDR_HI: wmask = `IOD_M_FULL;
            `IOD_A_TMR_GEN: wmask = `IOD_M_TMR_GEN;
            `IOD_A_T0_CTRL_A: wmask = `IOD_M_T0A;
            `IOD_A_T0_CTRL_B: wmask = `IOD_M_T0B;
            `IOD_A_T0_COUNT: wmask = `IOD_M_FULL;
            `IOD_A_T0_CMP_A: wmask = `IOD_M_FULL;
            `IOD_A_T0_CMP_B: wmask = `IOD_M_FULL;
            `IOD_A_GP1: wmask = `IOD_M_FULL;
            `IOD_A_GP2: wmask = `IOD_M_FULL;
            `IOD_A_SER_CTRL: wmask = `IOD_M_FULL;
            `IOD_A_SER_STATUS: wmask = `IOD_M_SER_STATUS;
            `IOD_A_SER_DATA: wmask = `IOD_M_FULL;
            `IOD_A_CMP_CTRL: wmask = `IOD_M_FULL;
            `IOD_A_SLEEP_CTRL: wmask = `IOD_M_SLEEP;
            `IOD_A_RST_CAUSE: wmask = `IOD_M_RSTCAUSE;
            `IOD_A_CORE_CTRL: wmask = `IOD_M_CORECTL;
            `IOD_A_SELF_PROG: wmask = `IOD_M_SELFPROG;
            `IOD_A_SP_LOW: wmask = `IOD_M_FULL;
            `IOD_A_SP_HIGH: wmask = `IOD_M_SP_HIGH;
            `IOD_A_STATUS: wmask = `IOD_M_FULL;
            default: wmask = `IOD_ZERO8;
         endcase
      end
   endfunction

   // bits that are event flags, cleared by writing a one
   function [7:0] cmask;
      input [5:0] a;
      begin
         case (a)
            `IOD_A_T0_FLAGS: cmask = `IOD_M_TFLAG;
            `IOD_A_T1_FLAGS: cmask = `IOD_M_TFLAG1;
            `IOD_A_T2_FLAGS: cmask = `IOD_M_TFLAG;
            `IOD_A_PIN_CHG_FLAGS: cmask = `IOD_M_TFLAG;
            `IOD_A_EXT_INT_FLAGS: cmask = `IOD_M_EXTFLAG;
            `IOD_A_CMP_CTRL: cmask = `IOD_C_ACI;
            default: cmask = `IOD_ZERO8;
         endcase
      end
   endfunction

   // a pending extended read owns rdata_q next cycle, so hold the core off
   assign req_ready = ~ext_rd_q;

   // request decode
   wire req_fire = req_valid & req_ready;
   wire is_port = (req_kind == `IOD_K_PORT_RD) | (req_kind == `IOD_K_PORT_WR);
   wire is_mem = (req_kind == `IOD_K_MEM_RD) | (req_kind == `IOD_K_MEM_WR);
   wire is_bset = (req_kind == `IOD_K_BIT_SET);
   wire is_bclr = (req_kind == `IOD_K_BIT_CLR);
   wire is_skip = (req_kind == `IOD_K_SKIP_SET) | (req_kind == `IOD_K_SKIP_CLR);
   wire is_bitop = is_bset | is_bclr | is_skip;
   wire is_write = (req_kind == `IOD_K_PORT_WR) | (req_kind == `IOD_K_MEM_WR);

   // data addresses below the i/o window belong to the core's own registers
   wire mem_io = is_mem & (req_addr >= `IOD_IO_OFS) & (req_addr < `IOD_EXT_BASE);
   wire mem_ext = is_mem & (req_addr >= `IOD_EXT_BASE);
   // bit operations above 0x1F are refused outright
   wire bit_ok = is_bitop & (req_addr[7:5] == `IOD_BIT_TOP_HI);

   // refused accesses still answer, so the core never stalls on them
   wire hit = req_fire & (is_port | mem_io | bit_ok);
   wire hit_wr = hit & (is_write | is_bset | is_bclr);

   // one index into the 64 locations for every kind of access
   always @*
   begin
      mem_io_addr = req_addr - `IOD_IO_OFS;
      if (is_port)
      begin
         idx = req_addr[`IOD_IO_WIDTH-1:0];
      end
      else if (is_mem)
      begin
         idx = mem_io_addr[`IOD_IO_WIDTH-1:0];
      end
      else
      begin
         idx = {1'b0, req_addr[4:0]};
      end
   end

   // value written into the addressed location
   always @*
   begin
      wm = wmask(idx);
      cm = cmask(idx);
      old = io_q[idx];
      bm = `IOD_ONE8 << req_bit;
      plain = wm & ~cm;
      wr_val = old;
      if (is_write)
      begin
         // flags clear on one, stay on zero
         wr_val = ((old & ~plain) | (req_wdata & plain)) & ~(req_wdata & cm);
      end
      else if (is_bset)
      begin
         if ((bm & cm) != `IOD_ZERO8)
         begin
            // setting a flag bit writes a one, which clears only that flag
            wr_val = old & ~bm;
         end
         else
         begin
            wr_val = old | (bm & wm);
         end
      end
      else if (is_bclr)
      begin
         if ((bm & cm) != `IOD_ZERO8)
         begin
            // writing zero to a flag leaves it alone
            wr_val = old;
         end
         else
         begin
            wr_val = old & ~(bm & wm);
         end
      end
   end

   // next state of the bank; a hardware event wins over a same-cycle clear
   always @*
   begin
      for (i = 0; i < `IOD_IO_COUNT; i = i + 1)
      begin
         io_d[i] = io_q[i];
         if (hit_wr && (idx == i[5:0]))
         begin
            io_d[i] = wr_val;
         end
         if (evt_valid && (evt_addr == i[5:0]))
         begin
            io_d[i] = io_d[i] | (evt_bits & cmask(i[5:0]));
         end
      end
   end

   // reserved slots stay zero: their mask never lets a write in
   always @(posedge ref_clk)
   begin
      for (j = 0; j < `IOD_IO_COUNT; j = j + 1)
      begin
         if (srst)
         begin
            io_q[j] <= `IOD_ZERO8;
         end
         else
         begin
            io_q[j] <= io_d[j];
         end
      end
   end

   // answers and the extended window
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         resp_valid_q <= 1'b0;
         rdata_q <= `IOD_ZERO8;
         skip_q <= 1'b0;
         ext_rd_q <= 1'b0;
         ext_wr_q <= 1'b0;
         ext_addr_q <= `IOD_ZERO8;
         ext_wdata_q <= `IOD_ZERO8;
      end
      else
      begin
         ext_rd_q <= req_fire & mem_ext & ~is_write;
         ext_wr_q <= req_fire & mem_ext & is_write;
         if (req_fire & mem_ext)
         begin
            ext_addr_q <= req_addr;
            ext_wdata_q <= req_wdata;
         end
         if (ext_rd_q)
         begin
            // extended read answers one cycle later than the rest
            resp_valid_q <= 1'b1;
            rdata_q <= ext_rdata;
            skip_q <= 1'b0;
         end
         else if (req_fire && !(mem_ext && !is_write))
         begin
            resp_valid_q <= 1'b1;
            skip_q <= 1'b0;
            if (hit)
            begin
               rdata_q <= io_q[idx] & wmask(idx);
            end
            else
            begin
               rdata_q <= `IOD_ZERO8;
            end
            if (hit && is_skip)
            begin
               if (req_kind == `IOD_K_SKIP_SET)
               begin
                  skip_q <= io_q[idx][req_bit];
               end
               else
               begin
                  skip_q <= ~io_q[idx][req_bit];
               end
            end
         end
         else
         begin
            resp_valid_q <= 1'b0;
            skip_q <= 1'b0;
         end
      end
   end

   // the core reads these directly, with no port request
   assign core_status = io_q[`IOD_A_STATUS];
   assign stack_ptr = {io_q[`IOD_A_SP_HIGH][2:0], io_q[`IOD_A_SP_LOW]};
endmodule
`default_nettype wire

/* File: verif/iod_chk_assertions.sv */
// assertion checker for the i/o space decoder ports
`timescale 1ns/1ps
`default_nettype none
module iod_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // request
   input wire logic req_valid,
   input wire logic [2:0] req_kind,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic req_ready,
   // answer
   input wire logic resp_valid_q,
   input wire logic [7:0] rdata_q,
   input wire logic skip_q,
   // extended window and core state
   input wire logic ext_rd_q,
   input wire logic ext_wr_q,
   input wire logic [7:0] ext_addr_q,
   input wire logic [7:0] ext_wdata_q,
   input wire logic [7:0] core_status
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   wire tk = req_valid && req_ready;
   wire ext = req_addr >= 8'h60 && req_kind[2:1] == 2'h1;
   AST_RESP: assert property (tk && !(ext && !req_kind[0]) |=> resp_valid_q)
      else $error("answer missing");
   AST_EXT_RD: assert property (tk && ext && !req_kind[0] |=> ext_rd_q && !req_ready
      && ext_addr_q == $past(req_addr) ##1 resp_valid_q) else $error("ext read");
   AST_EXT_WR: assert property (tk && ext && req_kind[0] |=> ext_wr_q
      && ext_wdata_q == $past(req_wdata)) else $error("ext write");
   AST_PORT_LOCAL: assert property (tk && req_kind[2:1] == 2'h0 |=> !ext_rd_q && !ext_wr_q)
      else $error("port went external");
   AST_BIT_RANGE: assert property (tk && req_kind[2] && req_addr > 8'h1F |=>
      rdata_q == 8'h00 && !skip_q) else $error("high bit op");
   AST_SKIP_ONLY: assert property (tk && req_kind[2:1] != 2'h3 |=> !skip_q)
      else $error("stray skip");
   AST_STATUS_PORT: assert property (tk && req_kind == 3'h1 && req_addr[5:0] == 6'h3F
      |=> core_status == $past(req_wdata)) else $error("port status");
   AST_STATUS_MEM: assert property (tk && req_kind == 3'h3 && req_addr == 8'h5F
      |=> core_status == $past(req_wdata)) else $error("mem status");
   AST_LOW_MEM: assert property (tk && req_kind == 3'h2 && req_addr < 8'h20
      |=> rdata_q == 8'h00) else $error("low mem read");
   cover property (tk && ext);
   cover property (skip_q);
   cover property (ext_wr_q);
endmodule
`default_nettype wire

/* File: verif/iod_ext_model.sv */
// model of the extended peripherals behind the load/store window
`timescale 1ns/1ps
`default_nettype none
module iod_ext_model (
   // clock
   input wire logic ref_clk,
   // window from the decoder
   input wire logic ext_rd_q,
   input wire logic ext_wr_q,
   input wire logic [7:0] ext_addr_q,
   input wire logic [7:0] ext_wdata_q,
   // read answer
   output logic [7:0] ext_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] last_q = 8'h00;
   // idle bus shows the inverse of the last byte, so a stale sample is caught
   assign ext_rdata = ext_rd_q ? mem[ext_addr_q] : ~last_q;
   always @(posedge ref_clk)
   begin
      if (ext_wr_q)
         mem[ext_addr_q] <= ext_wdata_q;
      if (ext_rd_q)
         last_q <= mem[ext_addr_q];
   end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the i/o space decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 0, srst = 1, req_valid = 0, evt_valid = 0, req_ready, resp_valid_q, skip_q, sk;
   logic ext_rd_q, ext_wr_q;
   logic [2:0] req_kind = 0, req_bit = 0;
   logic [7:0] req_addr = 0, req_wdata = 0, evt_bits = 0, rdata_q, ext_addr_q, ext_wdata_q;
   logic [7:0] ext_rdata, core_status, rd;
   logic [5:0] evt_addr = 0;
   logic [10:0] stack_ptr;
   integer fails = 0, samples_checked = 0;
   iod_io_space_decoder dut (
      .ref_clk(ref_clk),
      .srst(srst),
      .req_valid(req_valid),
      .req_kind(req_kind),
      .req_addr(req_addr),
      .req_bit(req_bit),
      .req_wdata(req_wdata),
      .req_ready(req_ready),
      .resp_valid_q(resp_valid_q),
      .rdata_q(rdata_q),
      .skip_q(skip_q),
      .evt_valid(evt_valid),
      .evt_addr(evt_addr),
      .evt_bits(evt_bits),
      .ext_rd_q(ext_rd_q),
      .ext_wr_q(ext_wr_q),
      .ext_addr_q(ext_addr_q),
      .ext_wdata_q(ext_wdata_q),
      .ext_rdata(ext_rdata),
      .core_status(core_status),
      .stack_ptr(stack_ptr)
   );
   iod_ext_model ext_peer (
      .ref_clk(ref_clk),
      .ext_rd_q(ext_rd_q),
      .ext_wr_q(ext_wr_q),
      .ext_addr_q(ext_addr_q),
      .ext_wdata_q(ext_wdata_q),
      .ext_rdata(ext_rdata)
   );
   initial forever #20 ref_clk = ~ref_clk;
   task close_out;
      begin
         $display("checked %0d mismatches %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input string n, input [10:0] e, input [10:0] g);
      begin
         samples_checked++;
         if (g !== e)
         begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task acc(input [2:0] k, input [7:0] a, input [2:0] b, input [7:0] w);
      integer i;
      begin
         @(posedge ref_clk);
         req_valid <= 1;
         req_kind <= k;
         req_addr <= a;
         req_bit <= b;
         req_wdata <= w;
         // hold the request until an edge at which ready stands high
         @(negedge ref_clk);
         while (req_ready !== 1'b1)
            @(negedge ref_clk);
         @(posedge ref_clk);
         req_valid <= 0;
         i = 0;
         @(negedge ref_clk);
         while (resp_valid_q !== 1'b1 && i < 4)
         begin
            @(negedge ref_clk);
            i++;
         end
         if (i == 4)
            chk("answer", 11'h001, 11'h000);
         rd = rdata_q;
         sk = skip_q;
      end
   endtask
   task evt(input [5:0] a, input [7:0] f);
      begin
         @(posedge ref_clk);
         evt_valid <= 1;
         evt_addr <= a;
         evt_bits <= f;
         @(posedge ref_clk);
         evt_valid <= 0;
      end
   endtask
   initial
   begin
      #200000;
      fails++;
      close_out;
   end
   initial
   begin
      repeat (2) @(posedge ref_clk);
      srst <= 0;
      acc(3'h0, 8'h3F, 3'h0, 8'h00);
      chk("status", 11'h000, rd);
      acc(3'h1, 8'h3F, 3'h0, 8'hA5);
      acc(3'h2, 8'h5F, 3'h0, 8'h00);
      chk("status mem", 11'h0A5, rd);
      acc(3'h3, 8'h5D, 3'h0, 8'h34);
      acc(3'h3, 8'h5E, 3'h0, 8'hFF);
      chk("stack", 11'h734, stack_ptr);
      acc(3'h1, 8'h1E, 3'h0, 8'h5A);
      acc(3'h4, 8'h1E, 3'h0, 8'h00);
      acc(3'h5, 8'h1E, 3'h6, 8'h00);
      acc(3'h0, 8'h1E, 3'h0, 8'h00);
      chk("gp bits", 11'h01B, rd);
      acc(3'h6, 8'h1E, 3'h0, 8'h00);
      chk("skip set", 11'h001, sk);
      acc(3'h7, 8'h1E, 3'h0, 8'h00);
      chk("skip clr", 11'h000, sk);
      acc(3'h7, 8'h1E, 3'h2, 8'h00);
      chk("skip clr", 11'h001, sk);
      acc(3'h5, 8'h3F, 3'h0, 8'h00);
      chk("status", 11'h0A5, core_status);
      acc(3'h0, 8'hFF, 3'h0, 8'h00);
      chk("port wrap", 11'h0A5, rd);
      evt(6'h15, 8'hFF);
      acc(3'h1, 8'h15, 3'h0, 8'h01);
      acc(3'h0, 8'h15, 3'h0, 8'h00);
      chk("flags", 11'h006, rd);
      acc(3'h4, 8'h15, 3'h2, 8'h00);
      acc(3'h1, 8'h15, 3'h0, 8'h00);
      acc(3'h0, 8'h15, 3'h0, 8'h00);
      chk("flags", 11'h002, rd);
      acc(3'h1, 8'h01, 3'h0, 8'hFF);
      acc(3'h0, 8'h01, 3'h0, 8'h00);
      chk("reserved", 11'h000, rd);
      acc(3'h3, 8'h10, 3'h0, 8'hFF);
      acc(3'h2, 8'h10, 3'h0, 8'h00);
      chk("low mem", 11'h000, rd);
      acc(3'h3, 8'h80, 3'h0, 8'hC3);
      acc(3'h2, 8'h80, 3'h0, 8'h00);
      chk("ext", 11'h0C3, rd);
      // second reset in mid-run: the bank must come back as zero
      @(posedge ref_clk);
      srst <= 1;
      repeat (2) @(posedge ref_clk);
      srst <= 0;
      @(negedge ref_clk);
      chk("status after reset", 11'h000, core_status);
      chk("stack after reset", 11'h000, stack_ptr);
      acc(3'h0, 8'h3F, 3'h0, 8'h00);
      chk("status port after reset", 11'h000, rd);
      close_out;
   end
endmodule
bind iod_io_space_decoder iod_chk u_chk (
   .ref_clk(ref_clk),
   .srst(srst),
   .req_valid(req_valid),
   .req_kind(req_kind),
   .req_addr(req_addr),
   .req_wdata(req_wdata),
   .req_ready(req_ready),
   .resp_valid_q(resp_valid_q),
   .rdata_q(rdata_q),
   .skip_q(skip_q),
   .ext_rd_q(ext_rd_q),
   .ext_wr_q(ext_wr_q),
   .ext_addr_q(ext_addr_q),
   .ext_wdata_q(ext_wdata_q),
   .core_status(core_status)
);
`default_nettype wire
